// File: verilog/srb_pkg.sv
// shared types and constants for the shift, rotate and bit-set unit
package srb_pkg;

   // datapath widths
   localparam int SRB_DATA_W = 16;
   localparam int SRB_BYTE_W = 8;
   localparam int SRB_REG_AW = 8;

   // register port offsets
   localparam logic [7:0] SRB_ADDR_FLAGS = 8'h00;
   localparam logic [7:0] SRB_ADDR_STATUS = 8'h04;

   // flag bit positions inside the flag register
   localparam int SRB_F_CARRY = 0;
   localparam int SRB_F_V = 1;
   localparam int SRB_F_P = 2;
   localparam int SRB_F_S = 3;
   localparam int SRB_F_Z = 4;
   localparam int SRB_F_AC = 5;
   localparam int SRB_F_DIR = 6;
   localparam int SRB_FLAG_W = 7;

   // status register fields
   localparam int SRB_ST_BUSY = 0;
   localparam int SRB_ST_STEPS_LSB = 8;

   // reset values and fixed patterns
   localparam logic [6:0] SRB_FLAGS_RST = 7'h00;
   localparam logic [15:0] SRB_ONE = 16'h0001;
   localparam logic [7:0] SRB_CNT_ONE = 8'h01;
   localparam logic [7:0] SRB_CNT_ZERO = 8'h00;
   localparam logic [7:0] SRB_BYTE_ZERO = 8'h00;
   localparam logic [3:0] SRB_IDX_BYTE_MASK = 4'h7;
   localparam logic [3:0] SRB_IDX_WORD_MASK = 4'hf;

   // operations of this instruction group
   typedef enum logic [2:0] {
      SRB_OP_NIBBLE_ROTATE_RIGHT,
      SRB_OP_ROTATE_RIGHT_THROUGH_CARRY,
      SRB_OP_BIT_SET,
      SRB_OP_LOGICAL_SHIFT_LEFT,
      SRB_OP_SET_CARRY,
      SRB_OP_SET_DIR
   } srb_op_t;

   // where a count or bit index comes from
   typedef enum logic [1:0] {
      SRB_CNT_FIXED_ONE,
      SRB_CNT_COUNT_REG,
      SRB_CNT_IMMEDIATE
   } srb_cnt_src_t;

   // request from decoder and operand fetch
   typedef struct packed {
      srb_op_t op;
      logic word;
      srb_cnt_src_t cnt_src;
      logic [7:0] imm;
      logic [15:0] operand;
      logic [7:0] accumulator_low_byte;
      logic [7:0] count_register_low;
   } srb_req_t;

   // result toward register file
   typedef struct packed {
      logic [15:0] value;
      logic [7:0] accumulator_low_byte;
      logic dst_we;
      logic acc_we;
   } srb_res_t;

endpackage

// File: verilog/srb_step.sv
// one-bit step of rotate right through carry or logical shift left
`timescale 1ns/1ps
`default_nettype none
module srb_step #(
   parameter int WIDTH = 16
) (
   // operand in
   input wire logic [WIDTH-1:0] value_in,
   input wire logic carry_in,
   input wire logic word,
   input wire logic shift_left,
   // operand out
   output logic [WIDTH-1:0] value_out,
   output logic carry_out,
   output logic msb_changed
);
   localparam int HB = WIDTH / 2 - 1;

   if (WIDTH < 4 || WIDTH % 2 != 0) begin : g_bad_width
      $error("srb_step needs an even width of at least 4");
   end
   logic old_msb;
   logic new_msb;

   // select the bit that acts as most significant for byte or word
   always_comb begin
      value_out = '0;
      carry_out = 1'b0;
      old_msb = word ? value_in[WIDTH-1] : value_in[HB];
      if (shift_left) begin
         carry_out = old_msb;
         value_out = {value_in[WIDTH-2:0], 1'b0};
         if (!word) begin
            value_out[WIDTH-1:HB+1] = '0;
         end
      end else begin
         carry_out = value_in[0];
         value_out = {1'b0, value_in[WIDTH-1:1]};
         if (word) begin
            value_out[WIDTH-1] = carry_in;
         end else begin
            value_out[WIDTH-1:HB+1] = '0;
            value_out[HB] = carry_in;
         end
      end
      new_msb = word ? value_out[WIDTH-1] : value_out[HB];
      msb_changed = old_msb ^ new_msb;
   end
endmodule
`default_nettype wire

// File: verilog/srb_szp.sv
// sign, zero and parity of a byte or word result
`timescale 1ns/1ps
`default_nettype none
module srb_szp #(
   parameter int WIDTH = 16
) (
   // result in
   input wire logic [WIDTH-1:0] value,
   input wire logic word,
   // flags out
   output logic zero,
   output logic sign,
   output logic parity
);
   localparam int HB = WIDTH / 2 - 1;

   if (WIDTH < 4 || WIDTH % 2 != 0) begin : g_bad_width
      $error("srb_szp needs an even width of at least 4");
   end

   // parity is even parity of the low byte
   always_comb begin
      sign = word ? value[WIDTH-1] : value[HB];
      zero = word ? (value == '0) : (value[HB:0] == '0);
      parity = ~^value[HB:0];
   end
endmodule
`default_nettype wire

// File: verilog/srb_unit.sv
// shift, rotate and bit-set execution unit with flag register
//
// Summary of operation
// [RL1] nibble rotate right moves digits right through accumulator low nibble
// [RL2] single rotate right through carry: bit 0 to carry, old carry to msb
// [RL3] single rotate through carry sets sign-change flag if msb changed
// [RL4] multi rotate repeats the one-bit step by count; sign-change undefined
// [RL5] two-operand bit set forces selected bit to one, flags untouched
// [RL6] count register bit index uses low 3 bits for bytes, 4 for words
// [RL7] immediate bit index from last byte, low 3 or 4 bits only
// [RL8] one-operand bit set of carry sets carry only
// [RL9] one-operand bit set of direction flag makes string ops decrement
// [RL10] single shift left inserts zero at bit 0, old msb to carry
// [RL11] single shift left sets sign-change flag only when sign bit changed
// [RL12] multi shift left inserts zeros, last bit out stays in carry
// [RL13] shift left updates parity, sign, zero; auxiliary carry undefined
// [RL14] size bit selects byte or word, hence bit 7 or bit 15 as msb
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module srb_unit #(
   parameter int DATA_W = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // request from decoder
   input wire logic req_valid,
   input wire srb_pkg::srb_req_t req,
   // result toward register file
   output logic res_valid,
   output srb_pkg::srb_res_t res,
   output logic busy,
   // flags toward flag register and string unit
   output logic [6:0] flags,
   output logic index_decrement,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata
);
   import srb_pkg::*;

   if (DATA_W != SRB_DATA_W) begin : g_bad_width
      $error("srb_unit serves only a 16-bit datapath");
   end

   typedef enum logic {SRB_ST_IDLE, SRB_ST_RUN} srb_state_t;

   srb_state_t state_r;
   logic [15:0] work_r;
   logic work_carry_r;
   logic [7:0] steps_r;
   srb_op_t op_r;
   logic word_r;
   logic [6:0] flags_r;
   logic res_valid_r;
   srb_res_t res_r;
   logic busy_r;
   logic [15:0] rdata_r;

   logic idle_take;
   logic [7:0] cnt_val;
   logic is_shift_req;
   logic cur_left;
   logic cur_word;
   logic [15:0] step_in;
   logic step_carry_in;
   logic [15:0] step_out;
   logic step_carry;
   logic step_chg;
   logic fin_shift;
   logic start_run;
   logic single_step;
   logic szp_z;
   logic szp_s;
   logic szp_p;
   logic [3:0] bit_idx;
   logic [15:0] setbit_val;
   logic [15:0] opnd_sized;
   logic [6:0] flags_nxt;

   // a request is only taken while idle
   assign idle_take = (state_r == SRB_ST_IDLE) && req_valid;

   // count source and the operation now in flight
   always_comb begin
      case (req.cnt_src)
         SRB_CNT_COUNT_REG: cnt_val = req.count_register_low;
         SRB_CNT_IMMEDIATE: cnt_val = req.imm;
         default: cnt_val = SRB_CNT_ONE;
      endcase
      is_shift_req = (req.op == SRB_OP_ROTATE_RIGHT_THROUGH_CARRY) ||
                     (req.op == SRB_OP_LOGICAL_SHIFT_LEFT);
      if (state_r == SRB_ST_RUN) begin
         cur_left = (op_r == SRB_OP_LOGICAL_SHIFT_LEFT);
         cur_word = word_r;
         step_in = work_r;
         step_carry_in = work_carry_r;
      end else begin
         cur_left = (req.op == SRB_OP_LOGICAL_SHIFT_LEFT);
         cur_word = req.word;
         step_in = opnd_sized;
         step_carry_in = flags_r[SRB_F_CARRY];
      end
   end

   // byte operands use only the low byte
   assign opnd_sized = req.word ? req.operand :
                       {SRB_BYTE_ZERO, req.operand[7:0]}; // RL14

   // one rotate or shift step per cycle
   srb_step #(.WIDTH(SRB_DATA_W)) u_step (
      .value_in(step_in),
      .carry_in(step_carry_in),
      .word(cur_word),
      .shift_left(cur_left),
      .value_out(step_out),
      .carry_out(step_carry),
      .msb_changed(step_chg)
   );

   // flags of the final shift result
   srb_szp #(.WIDTH(SRB_DATA_W)) u_szp (
      .value(step_out),
      .word(cur_word),
      .zero(szp_z),
      .sign(szp_s),
      .parity(szp_p)
   );

   // step sequencing decisions
   assign single_step = idle_take && is_shift_req && (cnt_val == SRB_CNT_ONE);
   assign start_run = idle_take && is_shift_req && (cnt_val > SRB_CNT_ONE);
   assign fin_shift = single_step ||
                      ((state_r == SRB_ST_RUN) && (steps_r == SRB_CNT_ONE));

   // bit index masking for the two-operand bit set
   always_comb begin
      bit_idx = (req.cnt_src == SRB_CNT_COUNT_REG) ?
                req.count_register_low[3:0] : req.imm[3:0]; // RL7
      bit_idx = bit_idx & (req.word ? SRB_IDX_WORD_MASK :
                           SRB_IDX_BYTE_MASK); // RL6
      setbit_val = opnd_sized | (SRB_ONE << bit_idx); // RL5
   end

   // state, work value and remaining step count
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_r <= SRB_ST_IDLE;
         work_r <= '0;
         work_carry_r <= 1'b0;
         steps_r <= SRB_CNT_ZERO;
         op_r <= SRB_OP_BIT_SET;
         word_r <= 1'b0;
      end else if (start_run) begin
         state_r <= SRB_ST_RUN;
         work_r <= step_out; // RL4
         work_carry_r <= step_carry;
         steps_r <= cnt_val - SRB_CNT_ONE;
         op_r <= req.op;
         word_r <= req.word;
      end else if (state_r == SRB_ST_RUN) begin
         work_r <= step_out; // RL12
         work_carry_r <= step_carry;
         steps_r <= steps_r - SRB_CNT_ONE;
         if (fin_shift) begin
            state_r <= SRB_ST_IDLE;
         end
      end
   end

   // flag register: hardware updates win over a software write
   always_comb begin
      flags_nxt = flags_r;
      if (reg_wr && (reg_addr == SRB_ADDR_FLAGS)) begin
         flags_nxt = reg_wdata[SRB_FLAG_W-1:0];
      end
      if (fin_shift) begin
         flags_nxt[SRB_F_CARRY] = step_carry; // RL2 RL10 RL12
         if (single_step) begin
            flags_nxt[SRB_F_V] = step_chg; // RL3 RL11
         end
         if (cur_left) begin
            flags_nxt[SRB_F_P] = szp_p; // RL13
            flags_nxt[SRB_F_S] = szp_s;
            flags_nxt[SRB_F_Z] = szp_z;
         end
      end
      if (idle_take && (req.op == SRB_OP_SET_CARRY)) begin
         flags_nxt[SRB_F_CARRY] = 1'b1; // RL8
      end
      if (idle_take && (req.op == SRB_OP_SET_DIR)) begin
         flags_nxt[SRB_F_DIR] = 1'b1; // RL9
      end
   end

   // flag storage
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         flags_r <= SRB_FLAGS_RST;
      end else begin
         flags_r <= flags_nxt;
      end
   end

   // result and its write enables
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         res_valid_r <= 1'b0;
         res_r <= '0;
      end else begin
         res_valid_r <= 1'b0;
         res_r.dst_we <= 1'b0;
         res_r.acc_we <= 1'b0;
         if (fin_shift) begin
            res_valid_r <= 1'b1;
            res_r.value <= step_out;
            res_r.dst_we <= 1'b1;
         end else if (idle_take) begin
            res_valid_r <= 1'b1;
            case (req.op)
               SRB_OP_NIBBLE_ROTATE_RIGHT: begin
                  res_r.value <= {SRB_BYTE_ZERO,
                     req.accumulator_low_byte[3:0], req.operand[7:4]}; // RL1
                  res_r.accumulator_low_byte <=
                     {req.accumulator_low_byte[7:4], req.operand[3:0]};
                  res_r.dst_we <= 1'b1;
                  res_r.acc_we <= 1'b1;
               end
               SRB_OP_BIT_SET: begin
                  res_r.value <= setbit_val; // RL5
                  res_r.dst_we <= 1'b1;
               end
               SRB_OP_ROTATE_RIGHT_THROUGH_CARRY,
               SRB_OP_LOGICAL_SHIFT_LEFT: begin
                  // zero count passes the operand through unchanged
                  res_valid_r <= !start_run;
                  res_r.value <= opnd_sized;
                  res_r.dst_we <= !start_run;
               end
               default: begin
                  res_r.value <= res_r.value;
               end
            endcase
         end
      end
   end

   // busy while further steps remain
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         busy_r <= 1'b0;
      end else begin
         busy_r <= start_run || ((state_r == SRB_ST_RUN) && !fin_shift);
      end
   end

   // register read data, valid the cycle after the strobe
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rdata_r <= '0;
      end else if (reg_rd) begin
         if (reg_addr == SRB_ADDR_FLAGS) begin
            rdata_r <= {9'h000, flags_r};
         end else if (reg_addr == SRB_ADDR_STATUS) begin
            rdata_r <= '0;
            rdata_r[SRB_ST_BUSY] <= busy_r;
            rdata_r[SRB_ST_STEPS_LSB +: 8] <= steps_r;
         end else begin
            rdata_r <= '0;
         end
      end else begin
         rdata_r <= '0;
      end
   end

   assign res_valid = res_valid_r;
   assign res = res_r;
   assign busy = busy_r;
   assign flags = flags_r;
   assign index_decrement = flags_r[SRB_F_DIR];
   assign reg_rdata = rdata_r;
   // helper signals watched by the checks below
   logic chk_msb_in;
   logic chk_wr_flags;
   assign chk_msb_in = req.word ? req.operand[15] : req.operand[7];
   assign chk_wr_flags = reg_wr && (reg_addr == SRB_ADDR_FLAGS);

   a_nibble_result: assert property (@(posedge clk) disable iff (reset) // RL1
      idle_take && req.op == SRB_OP_NIBBLE_ROTATE_RIGHT |=>
      res_valid_r && res_r.acc_we &&
      res_r.accumulator_low_byte[3:0] == $past(req.operand[3:0]) &&
      res_r.value[3:0] == $past(req.operand[7:4]) &&
      res_r.value[7:4] == $past(req.accumulator_low_byte[3:0]))
      else $error("nibble rotate result wrong");
   a_rotate_carry: assert property (@(posedge clk) disable iff (reset) // RL2
      single_step && req.op == SRB_OP_ROTATE_RIGHT_THROUGH_CARRY |=>
      flags_r[SRB_F_CARRY] == $past(req.operand[0]) && res_valid_r &&
      ($past(req.word) ? res_r.value[15] : res_r.value[7]) ==
      $past(flags_r[SRB_F_CARRY]))
      else $error("rotate through carry lost bit 0");
   a_rotate_vflag: assert property (@(posedge clk) disable iff (reset) // RL3
      single_step && req.op == SRB_OP_ROTATE_RIGHT_THROUGH_CARRY |=>
      flags_r[SRB_F_V] == ($past(chk_msb_in) ^ $past(flags_r[SRB_F_CARRY])))
      else $error("rotate sign-change flag wrong");
   a_run_countdown: assert property (@(posedge clk) disable iff (reset) // RL4
      state_r == SRB_ST_RUN && steps_r > SRB_CNT_ONE |=>
      state_r == SRB_ST_RUN && steps_r == $past(steps_r) - SRB_CNT_ONE)
      else $error("multi-step count not decreasing");
   a_setbit_flags: assert property (@(posedge clk) disable iff (reset) // RL5
      idle_take && req.op == SRB_OP_BIT_SET && !chk_wr_flags |=>
      $stable(flags_r) && res_valid_r && res_r.dst_we && !res_r.acc_we)
      else $error("bit set touched the flags");
   a_byte_index: assert property (@(posedge clk) disable iff (reset) // RL6
      idle_take && req.op == SRB_OP_BIT_SET && !req.word &&
      req.cnt_src == SRB_CNT_COUNT_REG |=>
      res_r.value[15:8] == SRB_BYTE_ZERO &&
      res_r.value[$past(req.count_register_low[2:0])])
      else $error("byte bit index not masked");
   a_set_carry: assert property (@(posedge clk) disable iff (reset) // RL8
      idle_take && req.op == SRB_OP_SET_CARRY |=>
      flags_r[SRB_F_CARRY] && !res_r.dst_we)
      else $error("carry not set");
   a_set_dir: assert property (@(posedge clk) disable iff (reset) // RL9
      idle_take && req.op == SRB_OP_SET_DIR |=> index_decrement)
      else $error("direction flag not set");
   a_shift_zero_in: assert property (@(posedge clk) disable iff (reset) // RL12
      fin_shift && cur_left |=> res_valid_r && !res_r.value[0])
      else $error("shift left did not insert zero");
   a_shift_vflag: assert property (@(posedge clk) disable iff (reset) // RL11
      single_step && req.op == SRB_OP_LOGICAL_SHIFT_LEFT |=>
      flags_r[SRB_F_CARRY] == $past(chk_msb_in) &&
      flags_r[SRB_F_V] == (flags_r[SRB_F_CARRY] ^ flags_r[SRB_F_S]))
      else $error("shift left carry or sign-change wrong");

endmodule
`default_nettype wire

// File: test/srb_regfile.sv
// register file model that takes the unit's write-back results
`timescale 1ns/1ps
`default_nettype none
module srb_regfile (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // result from the unit
   input wire logic res_valid,
   input wire srb_pkg::srb_res_t res,
   // stored destination and accumulator low byte
   output logic [15:0] dst_q,
   output logic [7:0] acc_q
);
   import srb_pkg::*;
   // destination written only on a result pulse with its enable
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         dst_q <= 16'h0000;
      end else if (res_valid && res.dst_we) begin
         dst_q <= res.value;
      end
   end
   // accumulator written only when the unit asks for it
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         acc_q <= 8'h00;
      end else if (res_valid && res.acc_we) begin
         acc_q <= res.accumulator_low_byte;
      end
   end
endmodule
`default_nettype wire

// File: test/test_shift_rotate_bitset_unit.sv
// self-checking bench for the shift, rotate and bit-set unit
`timescale 1ns/1ps
`default_nettype none
module test_shift_rotate_bitset_unit;
   import srb_pkg::*;
   typedef struct {
      srb_op_t op; logic w; srb_cnt_src_t src; logic [7:0] imm;
      logic [15:0] opnd; logic [7:0] acc; logic [7:0] cnt;
      logic [6:0] fin; logic [15:0] val; logic [6:0] fout;
   } srb_tb_row_t;
   localparam srb_op_t NR = SRB_OP_NIBBLE_ROTATE_RIGHT;
   localparam srb_op_t RC = SRB_OP_ROTATE_RIGHT_THROUGH_CARRY;
   localparam srb_op_t BS = SRB_OP_BIT_SET;
   localparam srb_op_t SL = SRB_OP_LOGICAL_SHIFT_LEFT;
   localparam srb_op_t SC = SRB_OP_SET_CARRY;
   localparam srb_op_t SD = SRB_OP_SET_DIR;
   localparam srb_cnt_src_t K1 = SRB_CNT_FIXED_ONE;
   localparam srb_cnt_src_t KC = SRB_CNT_COUNT_REG;
   localparam srb_cnt_src_t KI = SRB_CNT_IMMEDIATE;
   logic clk, reset, req_valid, reg_wr, reg_rd;
   logic res_valid, busy, index_decrement;
   srb_req_t req;
   srb_res_t res;
   logic [7:0] reg_addr, acc_q;
   logic [15:0] reg_wdata, reg_rdata, dst_q, rd;
   logic [6:0] flags;
   int fail_count, checks, n, lat;
   srb_tb_row_t r;
   srb_tb_row_t rows[16] = '{
      '{NR,0,K1,0,16'h0024,8'ha7,0,0,16'h0072,0},
      '{RC,0,K1,0,16'h0081,0,0,0,16'h0040,7'h03},
      '{RC,1,K1,0,16'h0002,0,0,7'h01,16'h8001,7'h02},
      '{RC,0,KC,0,16'h0005,0,3,0,16'h0040,7'h01},
      '{RC,1,KI,17,16'h1234,0,0,7'h01,16'h1234,7'h01},
      '{BS,0,KC,0,0,0,8'h0a,7'h1f,16'h0004,7'h1f},
      '{BS,1,KI,8'hff,16'h0001,0,0,0,16'h8001,0},
      '{BS,0,KI,8'h0f,16'h0010,0,0,0,16'h0090,0},
      '{BS,1,KC,0,0,0,8'h1c,0,16'h1000,0},
      '{SC,0,K1,0,0,0,0,0,0,7'h01},
      '{SD,0,K1,0,0,0,0,7'h01,0,7'h41},
      '{SL,0,K1,0,16'h0040,0,0,0,16'h0080,7'h0a},
      '{SL,1,K1,0,16'h8000,0,0,0,16'h0000,7'h17},
      '{SL,0,KI,3,16'h0031,0,0,0,16'h0088,7'h0d},
      '{SL,1,KC,0,16'h1234,0,0,7'h03,16'h1234,7'h03},
      '{SL,0,KC,0,16'h00c0,0,2,7'h22,16'h0000,7'h37}};
   srb_unit #(.DATA_W(16)) uut (.clk(clk), .reset(reset),
      .req_valid(req_valid), .req(req), .res_valid(res_valid), .res(res),
      .busy(busy), .flags(flags), .index_decrement(index_decrement),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   srb_regfile u_rf (.clk(clk), .reset(reset), .res_valid(res_valid),
      .res(res), .dst_q(dst_q), .acc_q(acc_q));
   // core clock, 4 ns period
   always #2 clk = ~clk;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_read(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // bounded wait for the result pulse, counting cycles from the take edge
   task automatic wait_res;
      n = 1;
      #1;
      while (res_valid !== 1'b1 && n < 300) begin
         @(posedge clk);
         #1 n++;
      end
   endtask
   task automatic run(input srb_tb_row_t x);
      @(posedge clk);
      req_valid <= 1'b1;
      req <= '{x.op, x.w, x.src, x.imm, x.opnd, x.acc, x.cnt};
      @(posedge clk);
      req_valid <= 1'b0;
      wait_res();
   endtask
   // hang guard
   initial begin
      #100000;
      fail_count++;
      close_out();
   end
   // main sequence
   initial begin
      clk = 0;
      reset = 1;
      req_valid = 0;
      req = '0;
      reg_wr = 0;
      reg_rd = 0;
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
      fail_count = 0;
      checks = 0;
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      #1 chk(flags, 0);
      chk(busy, 0);
      chk(res_valid, 0);
      chk(reg_rdata, 0);
      $display("test reset done");
      foreach (rows[i]) begin
         r = rows[i];
         reg_write(SRB_ADDR_FLAGS, {9'h000, r.fin});
         run(r);
         lat = (r.op != RC && r.op != SL) ? 1 : (r.src == K1) ? 1 :
               (r.src == KC) ? r.cnt : r.imm;
         if (lat < 1) lat = 1;
         chk(n, lat);
         chk(res.dst_we, !(r.op == SC || r.op == SD));
         chk(res.acc_we, r.op == NR);
         chk(flags, r.fout);
         chk(index_decrement, r.fout[6]);
         @(posedge clk);
         #1;
         if (r.op != SC && r.op != SD) begin
            chk(dst_q, r.val);
         end
         if (r.op == NR) chk(acc_q, {r.acc[7:4], r.opnd[3:0]});
         $display("test row %0d done", i);
      end
      // register port: readback, unmapped write and read
      reg_write(SRB_ADDR_FLAGS, 16'h005a);
      reg_read(SRB_ADDR_FLAGS, rd);
      chk(rd, 16'h005a);
      chk(index_decrement, 1);
      reg_write(8'h10, 16'h0000);
      reg_read(SRB_ADDR_FLAGS, rd);
      chk(rd, 16'h005a);
      reg_read(8'h10, rd);
      chk(rd, 16'h0000);
      $display("test register port done");
      // a request during a multi-step run is ignored
      reg_write(SRB_ADDR_FLAGS, 16'h0000);
      @(posedge clk);
      req_valid <= 1'b1;
      req <= '{SL, 1'b0, KI, 8'h04, 16'h0001, 8'h00, 8'h00};
      @(posedge clk);
      req.op <= SC;
      @(posedge clk);
      req_valid <= 1'b0;
      reg_rd <= 1'b1;
      reg_addr <= SRB_ADDR_STATUS;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata[0], 1);
      chk(reg_rdata[15:8], 8'h02);
      chk(busy, 1);
      wait_res();
      chk(res.value, 16'h0010);
      chk(flags, 7'h00);
      $display("test busy refusal done");
      // reset in mid-run clears the run and the flags
      reg_write(SRB_ADDR_FLAGS, 16'h0001);
      @(posedge clk);
      req_valid <= 1'b1;
      req <= '{SL, 1'b1, KI, 8'h20, 16'h0001, 8'h00, 8'h00};
      @(posedge clk);
      req_valid <= 1'b0;
      repeat (3) @(posedge clk);
      reset <= 1'b1;
      @(posedge clk);
      #1 chk(busy, 0);
      chk(flags, 7'h00);
      reset <= 1'b0;
      @(posedge clk);
      #1 chk(res_valid, 0);
      chk(busy, 0);
      run(rows[11]);
      chk(n, 1);
      chk(res.value, rows[11].val);
      chk(flags, rows[11].fout);
      $display("test mid-run reset done");
      close_out();
   end
endmodule
`default_nettype wire
